// file: shared/ccs_pkg.sv
package ccs_pkg;

  localparam int CODE_MAX_CHARS = 8;
  localparam int STEP_COUNT     = 18;
  localparam int STEP_W         = 5;
  localparam int VAL_W          = 32;
  localparam int CHAR_W         = 8;

  localparam logic [4:0] STEP_CH2_FIRST = 5'h09;
  localparam logic [4:0] STEP_NOARG_A   = 5'h03;
  localparam logic [4:0] STEP_NOARG_B   = 5'h07;
  localparam logic [4:0] STEP_NOARG_C   = 5'h0C;
  localparam logic [4:0] STEP_NOARG_D   = 5'h10;
  localparam logic [4:0] STEP_LAST      = 5'h11;

  localparam logic [11:0] YEAR_MIN  = 12'h7CE;
  localparam logic [11:0] YEAR_MAX  = 12'h831;
  localparam logic [3:0]  MONTH_MIN = 4'h1;
  localparam logic [3:0]  MONTH_MAX = 4'hC;
  localparam logic [4:0]  DAY_MIN   = 5'h01;
  localparam logic [4:0]  DAY_MAX   = 5'h1F;

  localparam logic [7:0] ERR_PENDING_MASK = 8'h04;

  localparam logic [7:0] CH_QUOTE = 8'h27;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_LF    = 8'h0A;

  typedef enum logic [3:0] {
    CCS_CMD_CODE  = 4'h0,
    CCS_CMD_INIT  = 4'h1,
    CCS_CMD_STEP  = 4'h2,
    CCS_CMD_DATE  = 4'h3,
    CCS_CMD_DATEQ = 4'h4,
    CCS_CMD_COUNT = 4'h5,
    CCS_CMD_SAVE  = 4'h6,
    CCS_CMD_LOCK  = 4'h7
  } ccs_cmd_e;

  typedef struct packed {
    ccs_cmd_e          cmd;
    logic [63:0]       code;
    logic [3:0]        code_len;
    logic [STEP_W-1:0] step;
    logic [VAL_W-1:0]  value;
    logic [11:0]       year;
    logic [3:0]        month;
    logic [4:0]        day;
  } ccs_req_s;

  typedef struct packed {
    logic       accepted;
    logic       refused;
    logic [4:0] next_step;
    logic       unlocked;
    logic       inited;
  } ccs_stat_s;

endpackage : ccs_pkg

// file: logic/ccs_sequencer.sv
`timescale 1ns/1ps
module ccs_sequencer (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 req_valid,
  input  wire ccs_pkg::ccs_req_s    req,
  output logic                      req_ready,
  output ccs_pkg::ccs_stat_s        stat,
  output logic                      tx_valid,
  output logic [7:0]                tx_char,
  input  wire logic                 tx_ready,
  input  wire logic [7:0]           status_byte,
  output logic                      err_pending
);

  typedef enum logic [1:0] {
    CCS_IDLE = 2'b00,
    CCS_SEND = 2'b01,
    CCS_DONE = 2'b10
  } ccs_state_e;

  localparam int BUF_N = 48;

  ccs_state_e           state_r;
  logic [7:0]           buf_r [BUF_N];
  logic [5:0]           len_r;
  logic [5:0]           idx_r;
  logic                 unlocked_r;
  logic                 inited_r;
  logic [4:0]           next_step_r;
  logic                 req_ready_r;
  logic                 tx_valid_r;
  logic [7:0]           tx_char_r;
  logic                 accepted_r;
  logic                 refused_r;
  logic [7:0]           sb_meta_r;
  logic [7:0]           sb_sync_r;
  logic                 err_r;
  ccs_pkg::ccs_cmd_e    cmd_r;

  function automatic logic is_alnum(input logic [7:0] c);
    return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h5A) || (c >= 8'h61 && c <= 8'h7A);
  endfunction : is_alnum

  function automatic logic [7:0] dig(input logic [3:0] d);
    return 8'h30 + {4'h0, d};
  endfunction : dig

  wire ccs_pkg::ccs_cmd_e cmd = req.cmd;

  logic code_ok;
  always_comb begin
    code_ok = (req.code_len != 4'h0) && (req.code_len <= 4'(ccs_pkg::CODE_MAX_CHARS));
    for (int i = 0; i < ccs_pkg::CODE_MAX_CHARS; i++) begin
      if (4'(i) < req.code_len && !is_alnum(req.code[63-8*i -: 8])) begin
        code_ok = 1'b0;
      end
    end
  end

  wire date_ok = req.year >= ccs_pkg::YEAR_MIN && req.year <= ccs_pkg::YEAR_MAX &&
                 req.month >= ccs_pkg::MONTH_MIN && req.month <= ccs_pkg::MONTH_MAX &&
                 req.day >= ccs_pkg::DAY_MIN && req.day <= ccs_pkg::DAY_MAX;
  wire step_noarg = req.step == ccs_pkg::STEP_NOARG_A || req.step == ccs_pkg::STEP_NOARG_B ||
                    req.step == ccs_pkg::STEP_NOARG_C || req.step == ccs_pkg::STEP_NOARG_D;
  wire step_ok = inited_r && req.step == next_step_r;
  wire save_ok = inited_r && next_step_r == 5'(ccs_pkg::STEP_COUNT);

  logic legal;
  always_comb begin
    unique case (cmd)
      ccs_pkg::CCS_CMD_CODE:  legal = code_ok;
      ccs_pkg::CCS_CMD_INIT:  legal = unlocked_r;
      ccs_pkg::CCS_CMD_STEP:  legal = unlocked_r && step_ok;
      ccs_pkg::CCS_CMD_SAVE:  legal = unlocked_r && save_ok;
      ccs_pkg::CCS_CMD_DATE:  legal = unlocked_r && inited_r && date_ok;
      ccs_pkg::CCS_CMD_DATEQ: legal = unlocked_r && inited_r;
      ccs_pkg::CCS_CMD_COUNT: legal = unlocked_r && inited_r;
      ccs_pkg::CCS_CMD_LOCK:  legal = unlocked_r;
      default:                legal = 1'b0;
    endcase
  end

  logic [7:0] line [BUF_N];
  logic [5:0] n;
  logic [31:0] v;
  always_comb begin
    for (int i = 0; i < BUF_N; i++) begin
      line[i] = ccs_pkg::CH_SPACE;
    end
    v = req.value;
    line[0] = ":"; line[1] = "c"; line[2] = "a"; line[3] = "l"; line[4] = ":";
    line[5] = "p"; line[6] = "r"; line[7] = "o"; line[8] = "t"; line[9] = ":";
    n = 6'd10;
    unique case (cmd)
      ccs_pkg::CCS_CMD_CODE: begin
        line[10] = "c"; line[11] = "o"; line[12] = "d"; line[13] = "e";
        line[15] = ccs_pkg::CH_QUOTE;
        for (int i = 0; i < ccs_pkg::CODE_MAX_CHARS; i++) begin
          if (4'(i) < req.code_len) line[16+i] = req.code[63-8*i -: 8];
        end
        line[6'd16 + 6'(req.code_len)] = ccs_pkg::CH_QUOTE;
        n = 6'd17 + 6'(req.code_len);
      end
      ccs_pkg::CCS_CMD_INIT: begin
        line[10] = "i"; line[11] = "n"; line[12] = "i"; line[13] = "t"; n = 6'd14;
      end
      ccs_pkg::CCS_CMD_SAVE: begin
        line[10] = "s"; line[11] = "a"; line[12] = "v"; line[13] = "e"; n = 6'd14;
      end
      ccs_pkg::CCS_CMD_LOCK: begin
        line[10] = "l"; line[11] = "o"; line[12] = "c"; line[13] = "k"; n = 6'd14;
      end
      ccs_pkg::CCS_CMD_COUNT: begin
        line[10] = "c"; line[11] = "o"; line[12] = "u"; line[13] = "n"; line[14] = "t"; line[15] = "?";
        n = 6'd16;
      end
      ccs_pkg::CCS_CMD_DATEQ: begin
        line[10] = "d"; line[11] = "a"; line[12] = "t"; line[13] = "e"; line[14] = "?"; n = 6'd15;
      end
      ccs_pkg::CCS_CMD_DATE: begin
        line[10] = "d"; line[11] = "a"; line[12] = "t"; line[13] = "e";
        line[15] = dig(4'(req.year / 1000)); line[16] = dig(4'((req.year / 100) % 10));
        line[17] = dig(4'((req.year / 10) % 10)); line[18] = dig(4'(req.year % 10));
        line[19] = ccs_pkg::CH_COMMA;
        line[20] = dig(4'(req.month / 10)); line[21] = dig(4'(req.month % 10));
        line[22] = ccs_pkg::CH_COMMA;
        line[23] = dig(4'(req.day / 10)); line[24] = dig(4'(req.day % 10));
        n = 6'd25;
      end
      ccs_pkg::CCS_CMD_STEP: begin
        line[10] = "s"; line[11] = "t"; line[12] = "e"; line[13] = "p";
        line[14] = dig(4'(req.step / 10)); line[15] = dig(4'(req.step % 10));
        n = 6'd16;
        if (!step_noarg) begin
          for (int i = 0; i < 10; i++) begin
            line[26-i] = dig(4'(v % 10));
            v = v / 10;
          end
          n = 6'd27;
        end
      end
      default: n = 6'd10;
    endcase
    line[n] = ccs_pkg::CH_LF;
  end

  wire take   = state_r == CCS_IDLE && req_valid && req_ready_r;
  wire last   = idx_r == len_r;
  wire beat   = state_r == CCS_SEND && tx_ready && tx_valid_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r     <= CCS_IDLE;
      len_r       <= 6'h00;
      idx_r       <= 6'h00;
      unlocked_r  <= 1'b0;
      inited_r    <= 1'b0;
      next_step_r <= 5'h00;
      req_ready_r <= 1'b0;
      tx_valid_r  <= 1'b0;
      tx_char_r   <= 8'h00;
      accepted_r  <= 1'b0;
      refused_r   <= 1'b0;
    end else begin
      accepted_r <= 1'b0;
      refused_r  <= 1'b0;
      unique case (state_r)
        CCS_IDLE: begin
          req_ready_r <= 1'b1;
          if (take) begin
            req_ready_r <= 1'b0;
            if (legal) begin
              state_r    <= CCS_SEND;
              // Count includes the closing LF so that it is sent too
              len_r      <= n + 6'h01;
              idx_r      <= 6'h01;
              tx_valid_r <= 1'b1;
              tx_char_r  <= line[0];
            end else begin
              refused_r <= 1'b1;
            end
          end
        end
        CCS_SEND: if (beat) begin
          if (last) begin
            tx_valid_r <= 1'b0;
            state_r    <= CCS_DONE;
          end else begin
            tx_char_r <= buf_r[idx_r];
            idx_r     <= idx_r + 6'h01;
          end
        end
        CCS_DONE: begin
          accepted_r <= 1'b1;
          state_r    <= CCS_IDLE;
          unique case (cmd_r)
            ccs_pkg::CCS_CMD_CODE: unlocked_r <= 1'b1;
            ccs_pkg::CCS_CMD_INIT: begin
              inited_r    <= 1'b1;
              next_step_r <= 5'h00;
            end
            ccs_pkg::CCS_CMD_STEP: next_step_r <= next_step_r + 5'h01;
            ccs_pkg::CCS_CMD_SAVE, ccs_pkg::CCS_CMD_LOCK: begin
              unlocked_r  <= 1'b0;
              inited_r    <= 1'b0;
              next_step_r <= 5'h00;
            end
            default: ;
          endcase
        end
        default: state_r <= CCS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) cmd_r <= ccs_pkg::CCS_CMD_CODE;
    else if (take) cmd_r <= cmd;
  end

  always_ff @(posedge clk) begin
    if (take) buf_r <= line;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sb_meta_r <= 8'h00;
      sb_sync_r <= 8'h00;
      err_r     <= 1'b0;
    end else begin
      sb_meta_r <= status_byte;
      sb_sync_r <= sb_meta_r;
      err_r     <= |(sb_sync_r & ccs_pkg::ERR_PENDING_MASK);
    end
  end

  assign req_ready   = req_ready_r;
  assign tx_valid    = tx_valid_r;
  assign tx_char     = tx_char_r;
  assign err_pending = err_r;
  assign stat        = '{accepted: accepted_r, refused: refused_r, next_step: next_step_r,
                         unlocked: unlocked_r, inited: inited_r};

endmodule : ccs_sequencer

// file: testbench/ccs_sequencer_checker.sv
`timescale 1ns/1ps
module ccs_sequencer_checker (
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic              req_valid,
  input wire ccs_pkg::ccs_req_s req,
  input wire logic              req_ready,
  input wire ccs_pkg::ccs_stat_s stat,
  input wire logic              tx_valid,
  input wire logic [7:0]        tx_char,
  input wire logic              tx_ready,
  input wire logic [7:0]        status_byte,
  input wire logic              err_pending
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire take = req_valid && req_ready;
  wire step = take && req.cmd == ccs_pkg::CCS_CMD_STEP;
  wire bad_date = req.year < ccs_pkg::YEAR_MIN || req.year > ccs_pkg::YEAR_MAX || req.month == 4'h0
    || req.month > 4'hC || req.day == 5'h00;
  locked_refuse_a: assert property (take && req.cmd != ccs_pkg::CCS_CMD_CODE && !stat.unlocked |=> stat.refused)
    else $error("command taken while locked was not refused");
  begin_first_a: assert property (step && stat.unlocked && !stat.inited |=> stat.refused)
    else $error("point before begin was not refused");
  step_order_a: assert property (step && stat.inited && req.step != stat.next_step |=> stat.refused)
    else $error("point out of order was not refused");
  save_early_a: assert property (take && req.cmd == ccs_pkg::CCS_CMD_SAVE && stat.next_step != 5'h12 |=> stat.refused)
    else $error("early commit was not refused");
  secret_long_a: assert property (take && req.cmd == ccs_pkg::CCS_CMD_CODE && req.code_len > 4'h8 |=> stat.refused)
    else $error("long secret was not refused");
  date_range_a: assert property (take && req.cmd == ccs_pkg::CCS_CMD_DATE && bad_date |=> stat.refused)
    else $error("date out of range was not refused");
  err_follow_a: assert property (err_pending == $past(status_byte[2], 3))
    else $error("error flag does not follow the status byte");
  disarm_lock_a: assert property (take && req.cmd == ccs_pkg::CCS_CMD_LOCK && stat.unlocked
    |-> ##[2:600] stat.accepted && !stat.unlocked)
    else $error("disarm did not lock");
endmodule : ccs_sequencer_checker
bind ccs_sequencer ccs_sequencer_checker ccs_sequencer_checker_i (.clk(clk), .rstn(rstn), .req_valid(req_valid),
  .req(req), .req_ready(req_ready), .stat(stat), .tx_valid(tx_valid), .tx_char(tx_char), .tx_ready(tx_ready),
  .status_byte(status_byte), .err_pending(err_pending));

// file: testbench/ccs_instr_model.sv
`timescale 1ns/1ps
module ccs_instr_model (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_char,
  input  wire logic       err_set,
  input  wire logic       err_clr,
  output logic            tx_ready,
  output logic [7:0]      status_byte,
  output logic [3:0]      quotes,
  output logic [3:0]      commas,
  output logic [15:0]     lines
);
  logic [3:0] q_r;
  logic [3:0] c_r;
  wire beat = tx_valid && tx_ready;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {tx_ready, status_byte, q_r, c_r, quotes, commas, lines} <= '0;
    end else begin
      // Random stalls exercise the hold of each character
      tx_ready <= ($urandom % 3) != 0;
      status_byte[1:0] <= 2'($urandom);
      if (err_set) status_byte[2] <= 1'b1;
      else if (err_clr) status_byte[2] <= 1'b0;
      if (beat && tx_char == 8'h0A) begin
        {quotes, commas, q_r, c_r} <= {q_r, c_r, 8'h00};
        lines <= lines + 16'h0001;
      end else if (beat) begin
        q_r <= q_r + 4'(tx_char == 8'h27);
        c_r <= c_r + 4'(tx_char == 8'h2C);
      end
    end
  end
endmodule : ccs_instr_model

// file: testbench/calibration_command_sequencer_test.sv
`timescale 1ns/1ps
module calibration_command_sequencer_test;
  logic               clk = 0, rstn = 0, req_valid = 0, err_set = 0, err_clr = 0;
  ccs_pkg::ccs_req_s  req = '0;
  ccs_pkg::ccs_stat_s stat;
  logic               req_ready, tx_valid, tx_ready, err_pending;
  logic [7:0]         tx_char, status_byte;
  logic [3:0]         quotes, commas;
  logic [15:0]        lines, exp_lines = 0;
  int                 n_fail = 0, checks_done = 0;
  logic [20:0]        bad_dates [5] = '{{12'h7CD, 4'h1, 5'h01}, {12'h832, 4'h1, 5'h01}, {12'h7D0, 4'h0, 5'h01},
                                        {12'h7D0, 4'hD, 5'h01}, {12'h7D0, 4'h1, 5'h00}};
  logic [3:0]         bad_len [3] = '{4'h9, 4'h0, 4'h8};
  always #20 clk = ~clk;
  ccs_sequencer ccs_sequencer_i (.clk(clk), .rstn(rstn), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .stat(stat), .tx_valid(tx_valid), .tx_char(tx_char), .tx_ready(tx_ready), .status_byte(status_byte),
    .err_pending(err_pending));
  ccs_instr_model ccs_instr_model_i (.clk(clk), .rstn(rstn), .tx_valid(tx_valid), .tx_char(tx_char),
    .err_set(err_set), .err_clr(err_clr), .tx_ready(tx_ready), .status_byte(status_byte), .quotes(quotes),
    .commas(commas), .lines(lines));
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask : tick
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask : check
  function automatic ccs_pkg::ccs_req_s mk(input ccs_pkg::ccs_cmd_e c, input logic [4:0] s = 5'h00);
    mk = '0;
    mk.cmd = c;
    mk.step = s;
    mk.value = $urandom;
  endfunction : mk
  function automatic ccs_pkg::ccs_req_s code_req(input logic [3:0] n);
    code_req = mk(ccs_pkg::CCS_CMD_CODE);
    // Arbitrary secret of letters and digits
    code_req.code = 64'h43414C3053454544;
    code_req.code_len = n;
  endfunction : code_req
  function automatic ccs_pkg::ccs_req_s date_req(input logic [20:0] d);
    date_req = mk(ccs_pkg::CCS_CMD_DATE);
    {date_req.year, date_req.month, date_req.day} = d;
  endfunction : date_req
  task automatic issue(input ccs_pkg::ccs_req_s r, input logic refuse, input string what);
    int k;
    k = 0;
    while (req_ready !== 1'b1 && k++ < 50) tick(1);
    req = r;
    req_valid = 1'b1;
    tick(1);
    req_valid = 1'b0;
    k = 0;
    while (stat.accepted !== 1'b1 && stat.refused !== 1'b1 && k++ < 600) tick(1);
    exp_lines += 16'(!refuse);
    check(stat.refused, refuse, what);
    check(stat.accepted, 32'(!refuse), what);
    tick(1);
    check(lines, exp_lines, what);
    $display("test %s done", what);
  endtask : issue
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  initial begin
    #(40 * 40000);
    n_fail++;
    end_of_test();
  end
  initial begin
    ccs_pkg::ccs_req_s r;
    void'($urandom(32'hEDDB));
    tick(16);
    rstn = 1'b1;
    tick(1);
    check(stat.unlocked, 1'b0, "locked after reset");
    check(stat.next_step, 5'h00, "sequence cleared after reset");
    issue(mk(ccs_pkg::CCS_CMD_STEP), 1'b1, "point while locked");
    issue(mk(ccs_pkg::CCS_CMD_COUNT), 1'b1, "tally while locked");
    for (int i = 0; i < 3; i++) begin
      r = code_req(bad_len[i]);
      if (i == 2) r.code[7:0] = 8'h2D;
      issue(r, 1'b1, "bad secret");
    end
    issue(code_req(4'($urandom_range(1, 8))), 1'b0, "secret");
    check(quotes, 4'h2, "secret quoted");
    issue(code_req(4'h8), 1'b0, "secret replaced");
    issue(mk(ccs_pkg::CCS_CMD_STEP), 1'b1, "point before begin");
    issue(mk(ccs_pkg::CCS_CMD_INIT), 1'b0, "begin");
    check(stat.inited, 1'b1, "begun");
    issue(mk(ccs_pkg::CCS_CMD_STEP, 5'h01), 1'b1, "point out of order");
    for (int i = 0; i < 18; i++) begin
      if (i == 9) issue(mk(ccs_pkg::CCS_CMD_SAVE), 1'b1, "early commit");
      issue(mk(ccs_pkg::CCS_CMD_STEP, 5'(i)), 1'b0, "point");
      check(stat.next_step, 32'(i + 1), "next point");
    end
    for (int i = 0; i < 5; i++) issue(date_req(bad_dates[i]), 1'b1, "bad date");
    issue(date_req({12'h831, 4'hC, 5'h1F}), 1'b0, "last date");
    issue(date_req({12'(1998 + $urandom % 100), 4'(1 + $urandom % 12), 5'(1 + $urandom % 31)}), 1'b0, "date");
    check(commas, 4'h2, "date separated");
    issue(mk(ccs_pkg::CCS_CMD_DATEQ), 1'b0, "date query");
    issue(mk(ccs_pkg::CCS_CMD_COUNT), 1'b0, "tally query");
    issue(mk(ccs_pkg::CCS_CMD_SAVE), 1'b0, "commit");
    issue(mk(ccs_pkg::CCS_CMD_SAVE), 1'b1, "commit while locked");
    issue(code_req(4'h8), 1'b0, "secret again");
    issue(mk(ccs_pkg::CCS_CMD_INIT), 1'b0, "begin again");
    issue(mk(ccs_pkg::CCS_CMD_STEP), 1'b0, "first point");
    issue(mk(ccs_pkg::CCS_CMD_LOCK), 1'b0, "disarm");
    check(stat.unlocked, 1'b0, "locked after disarm");
    issue(mk(ccs_pkg::CCS_CMD_STEP, 5'h01), 1'b1, "point after disarm");
    issue(mk(ccs_pkg::CCS_CMD_SAVE), 1'b1, "commit after abort");
    err_set = 1'b1;
    tick(1);
    err_set = 1'b0;
    tick(4);
    check(err_pending, 1'b1, "error flag raised");
    err_clr = 1'b1;
    tick(1);
    err_clr = 1'b0;
    tick(4);
    check(err_pending, 1'b0, "error flag cleared");
    end_of_test();
  end
endmodule : calibration_command_sequencer_test
